// >>> rtl/ivm_pkg.sv
// Purpose: constants and types for the interrupt vectoring and masking block
// Assumes: 20-bit cpu address space, 32-bit classic wishbone register bus
// Notes: register offsets are byte addresses on the wishbone bus
// Operation
// - peripheral requests maskable, share vectors 1-31
// - key request raised while any key low
// - edge inputs: rising, falling or both edges
// - accepted request reports its table entry address
// - fixed vectors: 4-byte entries, top of memory
// - fixed entry per trap, nmi and reset
// - break entry ff redirects to variable entry
// - variable table: 256 bytes from vector base
// - software number n at base plus 4n
// - numbers 10-11, 13-20 for bus, dma, key, a-d, serial
// - 21-23 timer a, 27-28 timer b, 29-31 edges
// - break and numbers 32-63 ignore global enable
// - two-wire mode swaps serial 2 request sources
// - enable, level, threshold gate maskable only
// - per-source control: request bit, level field
// - request bit shows outstanding request
// - accept: enabled, requested, level above threshold
// - three-bit level, zero disables, seven highest
// - hardware sets/clears request; software only clears
// - global enable gates all maskable requests
package ivm_pkg;
    localparam int ADDR_W = 20;
    localparam int WB_ADR_W = 8;
    localparam int LVL_W = 3;
    localparam int NUM_W = 6;
    localparam int KEY_W = 4;
    localparam int EXT_W = 3;

    localparam logic [7:0] OFS_VBASE = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_BRKFIX = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h80;

    localparam int CTRL_REQ_BIT = 3;
    localparam int FLAG_IE_BIT = 0;
    localparam int FLAG_THR_LSB = 4;
    localparam int MODE_TWB_BIT = 0;
    localparam int MODE_EDGE_LSB = 4;
    localparam int STAT_PEND_BIT = 31;
    localparam int STAT_NUM_LSB = 8;

    localparam logic [19:0] FIX_UNDEF = 20'hfffdc;
    localparam logic [19:0] FIX_OVF = 20'hfffe0;
    localparam logic [19:0] FIX_BREAK = 20'hfffe4;
    localparam logic [19:0] FIX_AMATCH = 20'hfffe8;
    localparam logic [19:0] FIX_STEP = 20'hfffec;
    localparam logic [19:0] FIX_WDOG = 20'hffff0;
    localparam logic [19:0] FIX_DBG = 20'hffff4;
    localparam logic [19:0] FIX_NMI = 20'hffff8;
    localparam logic [19:0] FIX_RESET = 20'hffffc;
    localparam logic [7:0] BREAK_REDIRECT = 8'hff;
    localparam int ENTRY_SHIFT = 2;
    localparam int VAR_TABLE_BYTES = 256;

    localparam logic [4:0] SN_BUSCOL = 5'h0a;
    localparam logic [4:0] SN_DMA_CH0 = 5'h0b;
    localparam logic [4:0] SN_KEY = 5'h0d;
    localparam logic [4:0] SN_AD = 5'h0e;
    localparam logic [4:0] SN_S2_TX = 5'h0f;
    localparam logic [4:0] SN_S2_RX = 5'h10;
    localparam logic [4:0] SN_EXT0 = 5'h1d;
    // numbers served by a source: 10,11,13-23,27-31
    localparam logic [31:0] SRC_MASK = 32'hf8ffec00;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    typedef enum logic [3:0] {
        KIND_UNDEF, KIND_OVF, KIND_BREAK, KIND_AMATCH, KIND_STEP,
        KIND_WDOG, KIND_DBG, KIND_NMI, KIND_RESET, KIND_SOFT
    } ivm_kind_t;
endpackage

// >>> rtl/ivm_pin_if.sv
`timescale 1ns/100ps
// Purpose: synchronised pin events between pin stage and controller
// Assumes: single clock domain
// Notes: all members are registered by the pin stage
interface ivm_pin_if;
    logic [ivm_pkg::KEY_W-1:0] key_low;
    logic [ivm_pkg::EXT_W-1:0] ext_rise;
    logic [ivm_pkg::EXT_W-1:0] ext_fall;
    modport pins (output key_low, output ext_rise, output ext_fall);
    modport ctrl (input key_low, input ext_rise, input ext_fall);
endinterface

// >>> rtl/ivm_pin_sync.sv
`timescale 1ns/100ps
// Purpose: three-stage pin synchroniser with edge and level detection
// Assumes: pins are asynchronous to clk_i
// Notes: a change counts once stages two and three agree
module ivm_pin_sync
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ivm_pkg::KEY_W-1:0] key_input_pin_n_i,
    input wire logic [ivm_pkg::EXT_W-1:0] external_edge_input_i,
    ivm_pin_if.pins pin
);
    import ivm_pkg::*;
    localparam int W = KEY_W + EXT_W;

    logic [W-1:0] s1_reg, s2_reg, s3_reg, stab_reg;
    logic [W-1:0] stab_next;
    logic [KEY_W-1:0] key_next;
    logic [EXT_W-1:0] rise_next, fall_next;

    always_comb
    begin
        // stage one feeds stage two only
        for (int i = 0; i < W; i++)
        begin
            stab_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : stab_reg[i];
        end
        key_next = ~stab_next[KEY_W-1:0];
        rise_next = stab_next[W-1:KEY_W] & ~stab_reg[W-1:KEY_W];
        fall_next = ~stab_next[W-1:KEY_W] & stab_reg[W-1:KEY_W];
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            // key pins idle high, so their stable state starts high
            s1_reg <= {{EXT_W{1'b0}}, {KEY_W{1'b1}}};
            s2_reg <= {{EXT_W{1'b0}}, {KEY_W{1'b1}}};
            s3_reg <= {{EXT_W{1'b0}}, {KEY_W{1'b1}}};
            stab_reg <= {{EXT_W{1'b0}}, {KEY_W{1'b1}}};
            pin.key_low <= '0;
            pin.ext_rise <= '0;
            pin.ext_fall <= '0;
        end
        else
        begin
            s1_reg <= {external_edge_input_i, key_input_pin_n_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stab_reg <= stab_next;
            pin.key_low <= key_next;
            pin.ext_rise <= rise_next;
            pin.ext_fall <= fall_next;
        end
    end
endmodule

// >>> rtl/ivm_ctrl.sv
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
// Purpose: request collection, masking, priority and vector addresses
// Assumes: requests on periph_req_i are synchronous to clk_i
// Notes: registers on classic wishbone, one wait state per access
module ivm_ctrl
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ivm_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] periph_req_i,
    input wire logic s2_nack_req_i,
    input wire logic s2_ack_req_i,
    input wire logic [ivm_pkg::KEY_W-1:0] key_input_pin_n_i,
    input wire logic [ivm_pkg::EXT_W-1:0] external_edge_input_i,
    input wire logic irq_take_i,
    input wire logic [4:0] irq_take_num_i,
    output logic irq_req_o,
    output logic [4:0] irq_num_o,
    output logic [ivm_pkg::LVL_W-1:0] irq_level_o,
    output logic [ivm_pkg::ADDR_W-1:0] irq_vec_o,
    input wire logic vec_req_i,
    input wire ivm_pkg::ivm_kind_t vec_kind_i,
    input wire logic [ivm_pkg::NUM_W-1:0] vec_num_i,
    output logic vec_valid_o,
    output logic [ivm_pkg::ADDR_W-1:0] vec_addr_o,
    output logic vec_maskable_o
);
    import ivm_pkg::*;

    ivm_pin_if pin ();

    ivm_pin_sync u_sync
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .key_input_pin_n_i(key_input_pin_n_i),
        .external_edge_input_i(external_edge_input_i),
        .pin(pin)
    );

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // variable table entry for a software number
    function automatic logic [ADDR_W-1:0] var_entry(
        input logic [ADDR_W-1:0] base, input logic [NUM_W-1:0] n);
        return base + ADDR_W'({n, 2'b00});
    endfunction

    // register file state
    logic [ADDR_W-1:0] vbase_reg, vbase_next;
    logic ie_reg, ie_next;
    logic [LVL_W-1:0] thr_reg, thr_next;
    logic twb_reg, twb_next;
    logic [2*EXT_W-1:0] edge_sel_reg, edge_sel_next;
    logic [7:0] brkfix_reg, brkfix_next;
    logic [31:0] req_reg, req_next;
    logic [LVL_W-1:0] lvl_reg [32];
    logic [LVL_W-1:0] lvl_next [32];
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;

    // outputs
    logic irq_req_next;
    logic [4:0] irq_num_next;
    logic [LVL_W-1:0] irq_level_next;
    logic [ADDR_W-1:0] irq_vec_next;
    logic vec_valid_next;
    logic [ADDR_W-1:0] vec_addr_next;
    logic vec_maskable_next;

    logic [31:0] src_req;
    logic [31:0] wdat;
    logic wr_en;
    logic rd_en;
    logic [WB_ADR_W-1:0] ctrl_ofs;
    logic ctrl_hit;
    logic [4:0] ctrl_idx;
    logic [LVL_W-1:0] best_lvl;
    logic [4:0] best_num;
    logic accept;

    // request sources by software number
    always_comb
    begin
        src_req = periph_req_i & SRC_MASK;
        src_req[SN_KEY] = |pin.key_low;
        if (twb_reg)
        begin
            src_req[SN_S2_TX] = s2_nack_req_i;
            src_req[SN_S2_RX] = s2_ack_req_i;
        end
        for (int e = 0; e < EXT_W; e++)
        begin
            unique case (edge_sel_reg[2*e +: 2])
                EDGE_FALL: src_req[SN_EXT0 + 5'(e)] = pin.ext_fall[e];
                EDGE_RISE: src_req[SN_EXT0 + 5'(e)] = pin.ext_rise[e];
                default: src_req[SN_EXT0 + 5'(e)] =
                    pin.ext_rise[e] | pin.ext_fall[e];
            endcase
        end
    end

    // highest level wins, lowest number on a tie
    always_comb
    begin
        best_lvl = '0;
        best_num = '0;
        for (int i = 0; i < 32; i++)
        begin
            if (SRC_MASK[i] && req_reg[i] && lvl_reg[i] > best_lvl)
            begin
                best_lvl = lvl_reg[i];
                best_num = 5'(i);
            end
        end
        // level 0 never beats 0, so disabled sources never win
        accept = ie_reg && (best_lvl > thr_reg);
    end

    // wishbone decode
    always_comb
    begin
        // write lands on the edge at which the master sees ack
        wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
        rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;
        wdat = wb_dat_i;
        ctrl_ofs = wb_adr_i - OFS_CTRL;
        ctrl_hit = (wb_adr_i >= OFS_CTRL) && (wb_adr_i[1:0] == 2'b00);
        ctrl_idx = ctrl_ofs[6:2];
    end

    // register file next state
    always_comb
    begin
        vbase_next = vbase_reg;
        ie_next = ie_reg;
        thr_next = thr_reg;
        twb_next = twb_reg;
        edge_sel_next = edge_sel_reg;
        brkfix_next = brkfix_reg;
        lvl_next = lvl_reg;
        req_next = req_reg;
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdat_next = '0;

        if (wr_en)
        begin
            unique case (wb_adr_i)
                OFS_VBASE: vbase_next =
                    ADDR_W'(merge(32'(vbase_reg), wdat, wb_sel_i));
                OFS_FLAG:
                begin
                    if (wb_sel_i[0])
                    begin
                        ie_next = wdat[FLAG_IE_BIT];
                        thr_next = wdat[FLAG_THR_LSB +: LVL_W];
                    end
                end
                OFS_MODE:
                begin
                    if (wb_sel_i[0])
                    begin
                        twb_next = wdat[MODE_TWB_BIT];
                    end
                    if (wb_sel_i[1])
                    begin
                        edge_sel_next = wdat[MODE_EDGE_LSB +: 2*EXT_W];
                    end
                end
                OFS_BRKFIX: if (wb_sel_i[0]) brkfix_next = wdat[7:0];
                default:
                begin
                    if (ctrl_hit && SRC_MASK[ctrl_idx] && wb_sel_i[0])
                    begin
                        lvl_next[ctrl_idx] = wdat[LVL_W-1:0];
                        // a one written to the request bit is ignored
                        if (!wdat[CTRL_REQ_BIT])
                        begin
                            req_next[ctrl_idx] = 1'b0;
                        end
                    end
                end
            endcase
        end

        if (irq_take_i)
        begin
            req_next[irq_take_num_i] = 1'b0;
        end
        // a new request beats any clear in the same cycle
        req_next = (req_next | src_req) & SRC_MASK;

        if (rd_en)
        begin
            unique case (wb_adr_i)
                OFS_VBASE: rdat_next = 32'(vbase_reg);
                OFS_FLAG: rdat_next = 32'({thr_reg, 3'b000, ie_reg});
                OFS_MODE: rdat_next = 32'({edge_sel_reg, 3'b000, twb_reg});
                OFS_STAT:
                begin
                    rdat_next[STAT_PEND_BIT] = irq_req_o;
                    rdat_next[STAT_NUM_LSB +: 5] = irq_num_o;
                    rdat_next[LVL_W-1:0] = irq_level_o;
                end
                OFS_BRKFIX: rdat_next = 32'(brkfix_reg);
                default:
                begin
                    if (ctrl_hit && SRC_MASK[ctrl_idx])
                    begin
                        rdat_next[CTRL_REQ_BIT] = req_reg[ctrl_idx];
                        rdat_next[LVL_W-1:0] = lvl_reg[ctrl_idx];
                    end
                end
            endcase
        end
    end

    // accepted request and vector lookup
    always_comb
    begin
        irq_req_next = accept;
        irq_num_next = best_num;
        irq_level_next = best_lvl;
        irq_vec_next = var_entry(vbase_reg, {1'b0, best_num});
        vec_valid_next = vec_req_i;
        vec_addr_next = vec_addr_o;
        vec_maskable_next = vec_maskable_o;
        if (vec_req_i)
        begin
            vec_maskable_next = 1'b0;
            unique case (vec_kind_i)
                KIND_UNDEF: vec_addr_next = FIX_UNDEF;
                KIND_OVF: vec_addr_next = FIX_OVF;
                KIND_BREAK: vec_addr_next = (brkfix_reg == BREAK_REDIRECT) ?
                    vbase_reg : FIX_BREAK;
                KIND_AMATCH: vec_addr_next = FIX_AMATCH;
                KIND_STEP: vec_addr_next = FIX_STEP;
                KIND_WDOG: vec_addr_next = FIX_WDOG;
                KIND_DBG: vec_addr_next = FIX_DBG;
                KIND_NMI: vec_addr_next = FIX_NMI;
                KIND_RESET: vec_addr_next = FIX_RESET;
                KIND_SOFT:
                begin
                    vec_addr_next = var_entry(vbase_reg, vec_num_i);
                    // only 1..31 are peripheral slots and maskable
                    vec_maskable_next = (vec_num_i != '0) &&
                        !vec_num_i[NUM_W-1];
                end
                default: vec_addr_next = FIX_UNDEF;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            vbase_reg <= '0;
            ie_reg <= 1'b0;
            thr_reg <= '0;
            twb_reg <= 1'b0;
            edge_sel_reg <= '0;
            brkfix_reg <= '0;
            req_reg <= RST_ZERO;
            for (int i = 0; i < 32; i++)
            begin
                lvl_reg[i] <= '0;
            end
            ack_reg <= 1'b0;
            rdat_reg <= RST_ZERO;
            irq_req_o <= 1'b0;
            irq_num_o <= '0;
            irq_level_o <= '0;
            irq_vec_o <= '0;
            vec_valid_o <= 1'b0;
            vec_addr_o <= '0;
            vec_maskable_o <= 1'b0;
        end
        else
        begin
            vbase_reg <= vbase_next;
            ie_reg <= ie_next;
            thr_reg <= thr_next;
            twb_reg <= twb_next;
            edge_sel_reg <= edge_sel_next;
            brkfix_reg <= brkfix_next;
            req_reg <= req_next;
            lvl_reg <= lvl_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            irq_req_o <= irq_req_next;
            irq_num_o <= irq_num_next;
            irq_level_o <= irq_level_next;
            irq_vec_o <= irq_vec_next;
            vec_valid_o <= vec_valid_next;
            vec_addr_o <= vec_addr_next;
            vec_maskable_o <= vec_maskable_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
endmodule

// >>> verification/ivm_ctrl_monitor.sv
// Purpose: port-level checks on the interrupt vectoring controller
// Assumes: single clock, reset_i asynchronous active high
// Notes: attached to every ivm_ctrl instance by bind
`timescale 1ns/100ps
module ivm_ctrl_monitor
    import ivm_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic irq_req_o,
    input wire logic [LVL_W-1:0] irq_level_o,
    input wire logic [ADDR_W-1:0] irq_vec_o,
    input wire logic vec_req_i,
    input wire ivm_pkg::ivm_kind_t vec_kind_i,
    input wire logic [NUM_W-1:0] vec_num_i,
    input wire logic vec_valid_o,
    input wire logic [ADDR_W-1:0] vec_addr_o,
    input wire logic vec_maskable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o) else $error("bus request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_vec_pulse: assert property (vec_req_i |=> vec_valid_o)
        else $error("lookup gave no valid");
    a_vec_cause: assert property (vec_valid_o |-> $past(vec_req_i))
        else $error("valid without lookup");
    a_reset_entry: assert property (vec_req_i && vec_kind_i == KIND_RESET
        |=> vec_addr_o == 20'hffffc) else $error("reset entry wrong");
    a_nmi_entry: assert property (vec_req_i && vec_kind_i == KIND_NMI
        |=> vec_addr_o == 20'hffff8) else $error("nmi entry wrong");
    a_soft_mask: assert property (vec_req_i && vec_kind_i == KIND_SOFT
        |=> vec_maskable_o == ($past(vec_num_i) inside {[1:31]}))
        else $error("soft maskable flag wrong");
    a_fixed_nomask: assert property (vec_req_i && vec_kind_i != KIND_SOFT
        |=> !vec_maskable_o) else $error("fixed entry maskable");
    a_irq_level: assert property (irq_req_o |-> irq_level_o != 3'h0)
        else $error("level zero accepted");
    a_irq_align: assert property (irq_req_o |-> irq_vec_o[1:0] == 2'h0)
        else $error("vector not on entry");
endmodule

bind ivm_ctrl ivm_ctrl_monitor i_mon (.clk_i(clk_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .irq_req_o(irq_req_o), .irq_level_o(irq_level_o), .irq_vec_o(irq_vec_o),
    .vec_req_i(vec_req_i), .vec_kind_i(vec_kind_i), .vec_num_i(vec_num_i),
    .vec_valid_o(vec_valid_o), .vec_addr_o(vec_addr_o),
    .vec_maskable_o(vec_maskable_o));

// >>> verification/ivm_cpu_model.sv
// Purpose: cpu sequencer stand-in that takes one vector per arming
// Assumes: arm_i is low between takes
// Notes: take number inverted when idle so stale values never match
`timescale 1ns/100ps
module ivm_cpu_model
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic arm_i,
    input wire logic irq_req_i,
    input wire logic [4:0] irq_num_i,
    output logic take_o,
    output logic [4:0] take_num_o
);
    logic armed_reg;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            armed_reg <= 1'b0;
            take_o <= 1'b0;
            take_num_o <= 5'h0;
        end
        else if (armed_reg && arm_i && irq_req_i)
        begin
            take_o <= 1'b1;
            take_num_o <= irq_num_i;
            armed_reg <= 1'b0;
        end
        else
        begin
            take_o <= 1'b0;
            take_num_o <= ~take_num_o;
            armed_reg <= armed_reg | ~arm_i;
        end
    end
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench for the interrupt vectoring controller
// Assumes: one clock, 50 MHz
// Notes: each scenario task drives and judges its own traffic
`timescale 1ns/100ps
module testbench;
    import ivm_pkg::*;
    logic clk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, preq = 32'h0;
    logic nack = 0, sack = 0, vreq = 0, arm = 0, take, irq, vval, vmask;
    logic [3:0] key_n = 4'hf;
    logic [2:0] ext = 3'h0, lvl;
    logic [4:0] tnum, inum;
    logic [19:0] ivec, vaddr;
    ivm_kind_t kind = KIND_SOFT;
    logic [5:0] vnum = 6'h0;
    int fails = 0, check_count = 0;
    localparam logic [19:0] BASE = 20'h12340;

    always #10 clk_i = ~clk_i;

    ivm_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .periph_req_i(preq), .s2_nack_req_i(nack), .s2_ack_req_i(sack),
        .key_input_pin_n_i(key_n), .external_edge_input_i(ext),
        .irq_take_i(take), .irq_take_num_i(tnum), .irq_req_o(irq),
        .irq_num_o(inum), .irq_level_o(lvl), .irq_vec_o(ivec),
        .vec_req_i(vreq), .vec_kind_i(kind), .vec_num_i(vnum),
        .vec_valid_o(vval), .vec_addr_o(vaddr), .vec_maskable_o(vmask));

    ivm_cpu_model i_cpu (.clk_i(clk_i), .reset_i(reset_i), .arm_i(arm),
        .irq_req_i(irq), .irq_num_i(inum), .take_o(take),
        .take_num_o(tnum));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            give_verdict();
        end
        q = rdat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(0, a, 32'h0, q);
    endtask

    task automatic vec(input ivm_kind_t k, input logic [5:0] n,
        input logic [19:0] exp, input logic m);
        @(posedge clk_i);
        vreq <= 1;
        kind <= k;
        vnum <= n;
        @(posedge clk_i);
        vreq <= 0;
        @(negedge clk_i);
        chk(vval, 1);
        chk(vaddr, exp);
        chk(vmask, m);
    endtask

    task automatic pulse(input logic [31:0] m);
        @(posedge clk_i);
        preq <= m;
        @(posedge clk_i);
        preq <= 32'h0;
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic [7:0] ofs [5] = '{OFS_VBASE, OFS_FLAG, OFS_MODE, OFS_STAT,
            OFS_BRKFIX};
        foreach (ofs[i])
        begin
            rd(ofs[i], q);
            chk(q, RST_ZERO);
        end
        rd(OFS_FLAG, q);
        chk(q, 32'h0);
        wr(OFS_VBASE, {12'h0, BASE});
        rd(OFS_VBASE, q);
        chk(q, {12'h0, BASE});
        rd(8'h40, q);
        chk(q, 32'h0);
        wr(8'hb8, 32'h0000_0003);
        rd(8'hb8, q);
        chk(q, 32'h3);
    endtask

    task automatic t_vectors();
        logic [5:0] nums [5] = '{6'd0, 6'd10, 6'd31, 6'd32, 6'd63};
        for (int k = 0; k < 9; k++)
            vec(ivm_kind_t'(k), 6'h0, 20'hfffdc + 20'(4 * k), 0);
        wr(OFS_BRKFIX, 32'hff);
        vec(KIND_BREAK, 6'h0, BASE, 0);
        wr(OFS_BRKFIX, 32'h0);
        foreach (nums[i])
            vec(KIND_SOFT, nums[i], BASE + 20'(4 * nums[i]),
                nums[i] inside {[1:31]});
    endtask

    task automatic t_accept();
        logic [31:0] q;
        wr(8'hb8, 32'h3);
        pulse(32'h1 << SN_AD);
        wr(OFS_FLAG, 32'h20);
        rd(OFS_STAT, q);
        chk(q[31], 0);
        wr(OFS_FLAG, 32'h31);
        rd(OFS_STAT, q);
        chk(q[31], 0);
        wr(OFS_FLAG, 32'h21);
        rd(OFS_STAT, q);
        chk({q[31], q[12:8], q[2:0]}, {1'b1, 5'd14, 3'd3});
        chk(ivec, BASE + 20'd56);
        chk({inum, lvl}, {5'd14, 3'd3});
        wr(8'hb8, 32'h0);
        rd(OFS_STAT, q);
        chk(q[31], 0);
    endtask

    task automatic t_prio();
        logic [31:0] q;
        int n;
        wr(OFS_FLAG, 32'h01);
        wr(8'hd4, 32'h5);
        wr(8'hd8, 32'h5);
        wr(8'hac, 32'h4);
        pulse(32'h0060_0800);
        rd(OFS_STAT, q);
        chk({q[12:8], q[2:0]}, {5'd21, 3'd5});
        @(posedge clk_i);
        arm <= 1;
        n = 0;
        while (take !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(take, 1);
        if (take !== 1'b1)
            give_verdict();
        arm <= 0;
        rd(8'hd4, q);
        chk(q, 32'h5);
        rd(OFS_STAT, q);
        chk({q[31], q[12:8]}, {1'b1, 5'd22});
        wr(8'hd8, 32'h0);
        wr(8'hac, 32'h0);
        wr(OFS_FLAG, 32'h0);
    endtask

    task automatic pins(input logic [7:0] a, input int cnt,
        input logic [2:0] exp);
        logic [31:0] q;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < cnt; i++)
        begin
            rd(a + 8'(4 * i), q);
            chk(q, {28'h0, exp[i], 3'h0});
            wr(a + 8'(4 * i), 32'h0);
        end
    endtask

    task automatic t_pins();
        @(posedge clk_i);
        key_n <= 4'hb;
        pins(8'hb4, 1, 3'h1);
        key_n <= 4'hf;
        wr(OFS_MODE, 32'h90);
        ext <= 3'h3;
        pins(8'hf4, 3, 3'h3);
        ext <= 3'h4;
        pins(8'hf4, 3, 3'h2);
        ext <= 3'h0;
        pins(8'hf4, 3, 3'h4);
    endtask

    task automatic t_twowire();
        wr(OFS_MODE, 32'h91);
        pulse(32'h1 << SN_S2_TX);
        pins(8'hbc, 1, 3'h0);
        @(posedge clk_i);
        nack <= 1;
        sack <= 1;
        @(posedge clk_i);
        nack <= 0;
        sack <= 0;
        pins(8'hbc, 2, 3'h3);
    endtask

    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_i <= 0;
        t_regs();
        t_vectors();
        t_accept();
        t_prio();
        t_pins();
        t_twowire();
        give_verdict();
    end
endmodule
